// file: rtl/vmp_buf2.sv
// two-entry output buffer, head always in slot 0
`timescale 1ns/1ps
module vmp_buf2 #(
  parameter int W = vmp_pkg::BYTE_W + 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  vmp_byte_if.snk bi,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_first
);
  import vmp_pkg::*;

  typedef struct packed {
    logic v0;
    logic v1;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
  } vmp_buf_t;

  vmp_buf_t st_ff;
  vmp_buf_t nxt_st;
  logic push;
  logic pop;

  assign bi.ready = !st_ff.v1;
  assign out_valid = st_ff.v0;
  assign out_data = st_ff.d0[7:0];
  assign out_first = st_ff.d0[8];

  always_comb begin
    nxt_st = st_ff;
    push = bi.valid && !st_ff.v1;
    pop = st_ff.v0 && out_ready;
    if (pop) begin
      nxt_st.d0 = st_ff.d1;
      nxt_st.v0 = st_ff.v1;
      nxt_st.v1 = 1'b0;
    end
    if (push) begin
      if (!nxt_st.v0) begin
        nxt_st.d0 = W'({bi.first, bi.data});
        nxt_st.v0 = 1'b1;
      end else begin
        nxt_st.d1 = W'({bi.first, bi.data});
        nxt_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // a stalled full buffer keeps both bytes
  full_hold_a: assert property (@(posedge mclk) disable iff (rst)
    st_ff.v1 && !out_ready |=> st_ff.v1 && $stable(st_ff.d0) && $stable(st_ff.d1))
    else $error("full buffer lost a byte under stall");
  stall_seen_c: cover property (@(posedge mclk) disable iff (rst)
    st_ff.v1 && !out_ready);

endmodule : vmp_buf2

// file: rtl/vmp_ser.sv
// packet to byte serialiser, most significant byte first
`timescale 1ns/1ps
module vmp_ser (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // packet in
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_pkt,
  // bytes out
  vmp_byte_if.src bo
);
  import vmp_pkg::*;

  typedef struct packed {
    logic busy;
    logic [1:0] idx;
    logic [31:0] sh;
  } vmp_ser_t;

  vmp_ser_t st_ff;
  vmp_ser_t nxt_st;

  assign in_ready = !st_ff.busy;
  assign bo.valid = st_ff.busy;
  assign bo.data = st_ff.sh[31:24];
  assign bo.first = st_ff.idx == 2'h0;

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.busy && bo.ready) begin
      nxt_st.sh = {st_ff.sh[23:0], 8'h00};
      nxt_st.idx = st_ff.idx + 2'h1;
      if (st_ff.idx == 2'h3) begin
        nxt_st.busy = 1'b0;
      end
    end
    if (in_valid && !st_ff.busy) begin
      nxt_st.busy = 1'b1;
      nxt_st.idx = 2'h0;
      nxt_st.sh = in_pkt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  msb_first_a: assert property (@(posedge mclk) disable iff (rst)
    in_valid && in_ready |=> bo.valid && bo.first && bo.data == $past(in_pkt[31:24]))
    else $error("packet did not open with byte 3");
  four_bytes_a: assert property (@(posedge mclk) disable iff (rst)
    st_ff.busy && st_ff.idx == 2'h3 && bo.ready |=> !st_ff.busy)
    else $error("serialiser did not stop after four bytes");

endmodule : vmp_ser

// file: rtl/vmp_top.sv
// vector and message packet formatter with apb status and control
//
// What this block does
// - vector packet: id, bad, slot, kind, argument, opcode
// - vector kind field is always 001
// - vector id is its word position
// - vector bad on over two errors or check
// - slot field carries phase a..d as 0..3
// - argument passed unchanged, meaning set by opcode
// - long-address good vector gets one message packet
// - message packets only after a good vector
// - message id is its word position
// - message packet: id, bad, slot, information bits
// - message id carries position within the frame
// - message bad on over two bit errors
// - information bits passed through unchanged
`timescale 1ns/1ps
module vmp_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vmp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded word from the frame decoder
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic wd_is_vector,
  input wire logic wd_long_addr,
  input wire logic [vmp_pkg::KIND_W-1:0] wd_vec_kind,
  input wire logic [vmp_pkg::WORD_POS_W-1:0] wd_word_number,
  input wire logic [vmp_pkg::SLOT_W-1:0] wd_slot,
  input wire logic [2:0] wd_bit_errors,
  input wire logic wd_check_fail,
  input wire logic [vmp_pkg::CNT_W-1:0] wd_msg_words,
  input wire logic [vmp_pkg::INFO_W-1:0] wd_data,
  // packet byte stream to the host link
  output logic pk_valid,
  input wire logic pk_ready,
  output logic [7:0] pk_byte,
  output logic pk_first
);
  import vmp_pkg::*;

  typedef struct packed {
    vmp_state_t state;
    logic wd_ready;
    logic [31:0] pkt;
    logic [CNT_W-1:0] msg_left;
    logic enable;
    logic [15:0] vec_cnt;
    logic [15:0] msg_cnt;
    logic [15:0] drop_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vmp_main_t;

  vmp_main_t st_ff;
  vmp_main_t nxt_st;
  logic ser_ready;
  logic ser_busy;
  logic acc;
  logic short_vec;
  logic bad_vec;
  logic bad_msg;
  logic emit_vec;
  logic emit_msg;
  logic apb_acc;
  logic apb_wr;
  logic clr;

  vmp_byte_if bytes_if ();

  function automatic logic addr_hit(input logic [APB_AW-1:0] a);
    return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_PKT_CNT ||
           a == ADDR_DROP_CNT || a == ADDR_LAST_PKT;
  endfunction : addr_hit

  function automatic logic [15:0] bump(input logic [15:0] v, input logic c, input logic e);
    logic [15:0] b;
    b = c ? 16'h0000 : v;
    return b + {15'h0000, e};
  endfunction : bump

  // vector packet: byte 2 bits 4..3 and byte 1 bits 7..6 left zero
  function automatic logic [31:0] fmt_vec(input logic [WORD_POS_W-1:0] wpos, input logic bad,
                                          input logic [SLOT_W-1:0] slot,
                                          input logic [INFO_W-1:0] d);
    logic [31:0] p;
    p = 32'h0000_0000;
    p[PK_ID_LO +: WORD_POS_W] = wpos;
    p[PK_BAD] = bad;
    p[PK_SLOT_LO +: SLOT_W] = slot;
    p[PK_KIND_LO +: KIND_W] = KIND_SHORT_INSTR;
    p[PK_ARG_LO +: ARG_W] = d[PK_ARG_LO +: ARG_W];
    p[PK_OP_LO +: OP_W] = d[PK_OP_LO +: OP_W];
    return p;
  endfunction : fmt_vec

  function automatic logic [31:0] fmt_msg(input logic [WORD_POS_W-1:0] wpos, input logic bad,
                                          input logic [SLOT_W-1:0] slot,
                                          input logic [INFO_W-1:0] d);
    logic [31:0] p;
    p = 32'h0000_0000;
    p[PK_ID_LO +: WORD_POS_W] = wpos;
    p[PK_BAD] = bad;
    p[PK_SLOT_LO +: SLOT_W] = slot;
    p[PK_INFO_LO +: INFO_W] = d;
    return p;
  endfunction : fmt_msg

  function automatic logic [31:0] rd_word(input logic [APB_AW-1:0] a, input vmp_main_t s,
                                          input logic sb);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ADDR_CTRL: r[CTRL_ENABLE_BIT] = s.enable;
      ADDR_STATUS: begin
        r[STAT_HOLD_BIT] = s.state == vmp_st_hold;
        r[STAT_SER_BIT] = sb;
        r[STAT_LEFT_LO +: CNT_W] = s.msg_left;
      end
      ADDR_PKT_CNT: r = {s.msg_cnt, s.vec_cnt};
      ADDR_DROP_CNT: r = {16'h0000, s.drop_cnt};
      ADDR_LAST_PKT: r = s.pkt;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_word

  always_comb begin
    nxt_st = st_ff;
    acc = wd_valid && st_ff.wd_ready;
    bad_vec = (wd_bit_errors > ERR_LIMIT) || wd_check_fail;
    bad_msg = wd_bit_errors > ERR_LIMIT;
    short_vec = wd_is_vector && wd_vec_kind == KIND_SHORT_INSTR;
    emit_vec = acc && st_ff.enable && short_vec;
    emit_msg = acc && st_ff.enable && !wd_is_vector && st_ff.msg_left != '0;
    apb_acc = psel && penable && !st_ff.pready;
    apb_wr = psel && penable && st_ff.pready && pwrite && paddr == ADDR_CTRL;
    clr = apb_wr && pwdata[CTRL_CLEAR_BIT];

    case (st_ff.state)
      vmp_st_idle: begin
        if (acc && st_ff.enable && wd_is_vector) begin
          // a bad vector closes the page so stray message words are dropped
          if (bad_vec) begin
            nxt_st.msg_left = '0;
          end else if (short_vec) begin
            nxt_st.msg_left = wd_long_addr ? COMPANION_WORDS : '0;
          end else begin
            nxt_st.msg_left = wd_msg_words;
          end
        end
        if (emit_vec) begin
          nxt_st.pkt = fmt_vec(wd_word_number, bad_vec, wd_slot, wd_data);
          nxt_st.state = vmp_st_hold;
        end else if (emit_msg) begin
          // companion words go out raw; the host discards their content
          nxt_st.pkt = fmt_msg(wd_word_number, bad_msg, wd_slot, wd_data);
          nxt_st.msg_left = st_ff.msg_left - 7'h01;
          nxt_st.state = vmp_st_hold;
        end
      end
      vmp_st_hold: begin
        if (ser_ready) begin
          nxt_st.state = vmp_st_idle;
        end
      end
      default: nxt_st.state = vmp_st_idle;
    endcase
    // one word in flight keeps the vector and its companion in order
    nxt_st.wd_ready = nxt_st.state == vmp_st_idle;

    nxt_st.vec_cnt = bump(st_ff.vec_cnt, clr, emit_vec);
    nxt_st.msg_cnt = bump(st_ff.msg_cnt, clr, emit_msg);
    nxt_st.drop_cnt = bump(st_ff.drop_cnt, clr, acc && !wd_is_vector && !emit_msg);

    // one wait state: pready comes from a flop
    nxt_st.pready = apb_acc;
    nxt_st.pslverr = apb_acc && !addr_hit(paddr);
    if (apb_acc) begin
      nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_word(paddr, st_ff, ser_busy);
    end
    if (apb_wr) begin
      nxt_st.enable = pwdata[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.state <= vmp_st_idle;
      st_ff.enable <= CTRL_ENABLE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wd_ready = st_ff.wd_ready;
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign ser_busy = !ser_ready;

  vmp_ser u_ser (
    .mclk(mclk),
    .rst(rst),
    .in_valid(st_ff.state == vmp_st_hold),
    .in_ready(ser_ready),
    .in_pkt(st_ff.pkt),
    .bo(bytes_if)
  );

  vmp_buf2 #(.W(BYTE_W + 1)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .bi(bytes_if),
    .out_valid(pk_valid),
    .out_ready(pk_ready),
    .out_data(pk_byte),
    .out_first(pk_first)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  vec_kind_a: assert property (emit_vec |=> st_ff.pkt[18:16] == 3'b001 && !st_ff.pkt[31])
    else $error("vector kind field not 001");
  vec_id_a: assert property (emit_vec |=> st_ff.pkt[30:24] == $past(wd_word_number))
    else $error("vector id differs from word position");
  vec_bad_a: assert property (emit_vec |=>
    st_ff.pkt[23] == ($past(wd_bit_errors) > 3'h2 || $past(wd_check_fail)))
    else $error("vector bad flag wrong");
  slot_field_a: assert property (emit_vec || emit_msg |=>
    st_ff.pkt[22:21] == $past(wd_slot))
    else $error("slot field differs from phase");
  vec_arg_a: assert property (emit_vec |=> st_ff.pkt[13:0] == $past(wd_data[13:0]))
    else $error("argument or opcode not passed through");
  // a stalled host can hold the word input low for tens of cycles
  companion_due_a: assert property (emit_vec && wd_long_addr && !bad_vec |=>
    st_ff.msg_left == 7'h01 ##[1:300] st_ff.wd_ready && st_ff.msg_left == 7'h01)
    else $error("companion message not armed after long vector");
  msg_gate_a: assert property (acc && !wd_is_vector && st_ff.msg_left == 7'h00 |=>
    st_ff.state == vmp_st_idle && $stable(st_ff.pkt))
    else $error("message packet sent without a good vector");
  msg_fields_a: assert property (emit_msg |=>
    st_ff.pkt[30:24] == $past(wd_word_number) && st_ff.pkt[20:0] == $past(wd_data) &&
    st_ff.pkt[23] == ($past(wd_bit_errors) > 3'h2) && !st_ff.pkt[31])
    else $error("message packet fields wrong");
  msg_count_a: assert property (emit_msg |=> st_ff.msg_left == $past(st_ff.msg_left) - 7'h01)
    else $error("message allowance not decremented");
  apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  vec_sent_c: cover property (emit_vec ##[1:8] pk_valid && pk_first);
  companion_c: cover property (emit_vec && wd_long_addr && !bad_vec ##[1:20] emit_msg);
  dropped_c: cover property (acc && !wd_is_vector && st_ff.msg_left == 7'h00);
  apb_err_c: cover property (pready && pslverr);

endmodule : vmp_top

// file: shared/vmp_byte_if.sv
// byte stream between serialiser and output buffer
`timescale 1ns/1ps
interface vmp_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic first;
  modport src (output valid, output data, output first, input ready);
  modport snk (input valid, input data, input first, output ready);
endinterface : vmp_byte_if

// file: shared/vmp_pkg.sv
// shared constants and types for the vector and message packet formatter
package vmp_pkg;

  // register bus
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PKT_CNT = 12'h008;
  localparam logic [11:0] ADDR_DROP_CNT = 12'h00c;
  localparam logic [11:0] ADDR_LAST_PKT = 12'h010;

  // control register fields and reset value
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  // status register fields
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_SER_BIT = 1;
  localparam int STAT_LEFT_LO = 8;

  // word input widths
  localparam int WORD_POS_W = 7;
  localparam int SLOT_W = 2;
  localparam int KIND_W = 3;
  localparam int ARG_W = 11;
  localparam int OP_W = 3;
  localparam int INFO_W = 21;
  localparam int CNT_W = 7;
  localparam int BYTE_W = 8;

  // packet field positions, byte 3 is bits 31..24
  localparam int PK_ZERO = 31;
  localparam int PK_ID_LO = 24;
  localparam int PK_BAD = 23;
  localparam int PK_SLOT_LO = 21;
  localparam int PK_KIND_LO = 16;
  localparam int PK_ARG_LO = 3;
  localparam int PK_OP_LO = 0;
  localparam int PK_INFO_LO = 0;

  // argument layout for temporary address assignment
  localparam int ARG_TEMP_ID_LO = 7;
  localparam int ARG_CYCLE_LO = 0;

  // codes
  localparam logic [2:0] KIND_SHORT_INSTR = 3'h1;
  localparam logic [2:0] OP_TEMP_ADDR = 3'h0;
  localparam logic [2:0] OP_TEST = 3'h7;
  localparam logic [2:0] ERR_LIMIT = 3'h2;
  localparam logic [6:0] COMPANION_WORDS = 7'h01;

  typedef enum logic [1:0] {
    vmp_st_idle = 2'b01,
    vmp_st_hold = 2'b10
  } vmp_state_t;

endpackage : vmp_pkg

// file: verif/tb.sv
// self-checking bench for the packet formatter
`timescale 1ns/1ps
module tb;
  import vmp_pkg::*;
  typedef struct {logic [31:0] p; logic [31:0] m;} vmp_exp_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr;
  logic wd_valid = 1'b0, wd_is_vector = 1'b0, wd_long_addr = 1'b0, wd_check_fail = 1'b0;
  logic [2:0] wd_vec_kind = 3'h0, wd_bit_errors = 3'h0;
  logic [6:0] wd_word_number = 7'h0, wd_msg_words = 7'h0;
  logic [1:0] wd_slot = 2'h0;
  logic [20:0] wd_data = 21'h0;
  logic wd_ready, pk_valid, pk_ready, pk_first, got_stb;
  logic slow = 1'b0;
  logic [7:0] pk_byte;
  logic [31:0] got_pkt;
  logic [3:0] got_first;
  int err_count = 0, cmp_count = 0, vcnt = 0, mcnt = 0, dcnt = 0;
  int allow = 0, comp = 0, en = 1, n;
  int seed = 32'h65764e22;
  vmp_exp_t q[$];
  vmp_exp_t e;

  vmp_top DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wd_valid, .wd_ready, .wd_is_vector, .wd_long_addr, .wd_vec_kind,
    .wd_word_number, .wd_slot, .wd_bit_errors, .wd_check_fail, .wd_msg_words, .wd_data,
    .pk_valid, .pk_ready, .pk_byte, .pk_first);
  vmp_host_model host (.mclk, .rst, .pk_valid, .pk_ready, .pk_byte, .pk_first, .slow,
    .got_stb, .got_pkt, .got_first);

  initial forever #12.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Compared %0d values, %0d errors", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, ex,
                     input logic ee);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    if (!w) chk(prdata, ex);
    chk({31'h0, pslverr}, {31'h0, ee});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // offers one decoded word and notes the packet it should produce
  task automatic word(input logic v, lg, input logic [2:0] k, input logic [6:0] wpos,
                      input logic [1:0] sl, input logic [2:0] er, input logic cf,
                      input logic [6:0] mw, input logic [20:0] d);
    logic bad;
    int t;
    bad = er > 3'h2 || (v && cf);
    wd_valid <= 1'b1;
    {wd_is_vector, wd_long_addr, wd_vec_kind, wd_word_number, wd_slot, wd_bit_errors,
      wd_check_fail, wd_msg_words, wd_data} <= {v, lg, k, wpos, sl, er, cf, mw, d};
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (wd_ready !== 1'b1 && t < 200);
    if (t == 200) err_count++;
    wd_valid <= 1'b0;
    if (en && v && k == KIND_SHORT_INSTR) begin
      q.push_back('{{1'b0, wpos, bad, sl, 5'h01, 2'h0, d[13:0]}, 32'hffe73fff});
      vcnt++;
      allow = lg && !bad;
      comp = allow;
    end else if (en && v) begin
      allow = bad ? 0 : int'(mw);
      comp = 0;
    end else if (en && allow > 0) begin
      // companion info bits carry nothing, so they are masked out
      q.push_back('{{1'b0, wpos, er > 3'h2, sl, d}, comp ? 32'hffe00000 : 32'hffffffff});
      allow--;
      comp = 0;
      mcnt++;
    end else if (en) begin
      dcnt++;
    end
    @(posedge mclk);
  endtask : word

  always @(posedge mclk) begin
    if (got_stb === 1'b1) begin
      if (q.size() > 0) e = q.pop_front();
      else e = '{~got_pkt, 32'hffffffff};
      chk(got_pkt & e.m, e.p & e.m);
      chk({28'h0, got_first}, 32'h8);
    end
  end

  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, ADDR_CTRL, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h040, 32'hffffffff, 32'h0, 1'b1);
    // every opcode, error counts across the limit, both address kinds
    for (int i = 0; i < 8; i++) begin
      word(1'b1, i[0], KIND_SHORT_INSTR, 7'(2 + i * 12), i[1:0], {1'b0, i[2:1]}, i == 5,
           7'h0, {18'($random(seed)), 3'(i)});
      word(1'b0, 1'b0, 3'h0, 7'(3 + i), 2'(i), 3'h0, 1'b0, 7'h0, 21'($random(seed)));
    end
    // random traffic while the host stalls
    slow <= 1'b1;
    repeat (60) begin
      r = $random(seed);
      if (r[0]) word(1'b1, r[1], r[2] ? KIND_SHORT_INSTR : r[5:3], 7'(2 + r[15:8] % 86),
                     r[7:6], r[18:16], r[19], 7'(r[21:20]), 21'($random(seed)));
      else word(1'b0, 1'b0, 3'h0, 7'(3 + r[15:8] % 85), r[7:6], r[18:16], 1'b0, 7'h0,
                21'($random(seed)));
    end
    slow <= 1'b0;
    n = 0;
    while (q.size() > 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(q.size()), 32'h0);
    apb(1'b0, ADDR_PKT_CNT, 32'h0, {16'(mcnt), 16'(vcnt)}, 1'b0);
    apb(1'b0, ADDR_DROP_CNT, 32'h0, 32'(dcnt), 1'b0);
    // disabled block swallows a word, then counters are cleared
    apb(1'b1, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
    en = 0;
    word(1'b1, 1'b1, KIND_SHORT_INSTR, 7'h05, 2'h0, 3'h0, 1'b0, 7'h0, 21'h0);
    apb(1'b1, ADDR_CTRL, 32'h3, 32'h0, 1'b0);
    en = 1;
    word(1'b1, 1'b0, 3'h3, 7'h06, 2'h1, 3'h3, 1'b0, 7'h2, 21'h0);
    word(1'b0, 1'b0, 3'h0, 7'h07, 2'h1, 3'h0, 1'b0, 7'h0, 21'h1);
    repeat (20) @(posedge mclk);
    apb(1'b0, ADDR_CTRL, 32'h0, 32'h1, 1'b0);
    apb(1'b0, ADDR_PKT_CNT, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_DROP_CNT, 32'h0, 32'h1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    chk(32'(q.size()), 32'h0);
    end_of_test;
  end
endmodule : tb

// file: verif/vmp_host_model.sv
// host side reader: takes packet bytes and rebuilds whole packets
`timescale 1ns/1ps
module vmp_host_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // byte stream from the block
  input wire logic pk_valid,
  output logic pk_ready,
  input wire logic [7:0] pk_byte,
  input wire logic pk_first,
  // pacing and rebuilt packets
  input wire logic slow,
  output logic got_stb,
  output logic [31:0] got_pkt,
  output logic [3:0] got_first
);
  logic [3:0] pace_ff;
  logic [1:0] idx_ff;

  // slow pace takes one byte in eight so the buffer fills and stalls
  always_ff @(posedge mclk) begin
    if (rst) begin
      pace_ff <= 4'h0;
      idx_ff <= 2'h0;
      pk_ready <= 1'b0;
      got_stb <= 1'b0;
      got_pkt <= 32'h0;
      got_first <= 4'h0;
    end else begin
      pace_ff <= pace_ff + 4'h1;
      pk_ready <= !slow || pace_ff[2:0] == 3'h5;
      got_stb <= pk_valid && pk_ready && idx_ff == 2'h3;
      if (pk_valid && pk_ready) begin
        got_pkt <= {got_pkt[23:0], pk_byte};
        got_first <= {got_first[2:0], pk_first};
        idx_ff <= idx_ff + 2'h1;
      end
    end
  end
endmodule : vmp_host_model
